// ---- nbu_uart.sv ----
// nine-bit asynchronous serial port with apb register access
//
// Behaviour
// - nine-bit frames are 11 bits: start 0, eight data, ninth, stop 1.
// - a buffer write takes the ninth bit from the transmit ninth bit.
// - transmit starts five cycles after the first counter rollover following the write.
// - send start, data lsb first, ninth bit, then stop.
// - transmit done flag sets as the stop bit is driven.
// - receive only while baud source runs and receive enable is set.
// - a falling receive edge starts a frame, then sample at baud rate.
// - at mid ninth bit accept if done flag clear and multiprocessor bit allows.
// - accepted word loads buffer, ninth flag, done flag; rejected leaves them.
// - after mid stop bit return to waiting for a falling edge.
// - each bit is a majority vote of three samples.
// - mode 2 feeds the counter with clock over 2 or 4: rate over 32 or 64.
// - the baud doubler resets to 0.
// - mode 3 equals mode 2 but times bits from the phase generator.
// - mode 0 shift clock is system clock over 12, or over 4.
// - clock divide modes scale mode 0 and mode 2 rates only.
// - generator adds phase every clock with doubler, every fourth without.
// - each carry out of bit 16 is one generator pulse.
// - generator output is divided by 16 for modes 1 and 3.
// - a missing stop bit sets the framing error flag.
// - framing error stays set until software clears it.
// - select bit picks framing error or mode bit 0 at control bit 7.
// - buffer write loads transmit data; buffer read returns receive data.
// - samples are taken on ticks 7, 8 and 9 of the counter.
// - a start bit voted high is abandoned.
module nbu_uart
  import nbu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rxd,
  output logic o_rxd_out,
  output logic o_rxd_oe,
  output logic o_txd
);
  // register state
  nbu_serial_control_reg_t serial_control_reg_r, serial_control_reg_nxt;
  nbu_clkdiv_t div_r, div_nxt;
  logic fe_r, fe_nxt, framing_detect_select_r, framing_detect_select_nxt, baud_doubler_r, baud_doubler_nxt;
  logic [NBU_PHASE_W-1:0] phase_r, phase_nxt;
  logic [7:0] rxbuf_r, rxbuf_nxt, txbuf_r, txbuf_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic hit, wr, ctrl_wr, mode_wr, buf_wr, rd_setup;
  logic [31:0] rd_val;
  // prescaler state
  logic [7:0] sys_cnt_r, sys_cnt_nxt, sys_last;
  logic [1:0] m2_cnt_r, m2_cnt_nxt, gen_cnt_r, gen_cnt_nxt;
  logic [3:0] m0_cnt_r, m0_cnt_nxt, m0_last, m0_half, sub16_r, sub16_nxt;
  logic eff_tick, m2_tick, m0_tick, gen_step, gen_pulse, sub_tick, roll;
  logic [1:0] mode;
  // transmit state
  nbu_tx_state_t tx_st_r, tx_st_nxt;
  logic [10:0] frame_r, frame_nxt;
  logic [3:0] tx_idx_r, tx_idx_nxt, tx_sub_r, tx_sub_nxt, tx_last;
  logic [2:0] dly_r, dly_nxt;
  logic txd_r, txd_nxt, tx_ti_set, buf_wr_ok, tx_bit_end;
  // receive state
  nbu_rx_state_t rx_st_r, rx_st_nxt;
  logic rxd_s1_r, rxd_s2_r, rxd_d_r;
  logic [3:0] rx_sub_r, rx_sub_nxt, rx_idx_r, rx_idx_nxt, rx_last;
  logic [1:0] votes_r, votes_nxt;
  logic [7:0] rx_shift_r, rx_shift_nxt;
  logic rx_enable, rx_bit, rx_mid, rx_accept, rx_load, rx_fe_set;
  logic rx_abort;

  assign mode = {serial_control_reg_r.sm0, serial_control_reg_r.sm1};

  // apb decode; zero wait states, so every access completes at once
  always_comb begin
    hit = 1'b1;
    rd_val = NBU_RDATA_NONE;
    if (i_paddr == NBU_ADDR_CTRL) begin
      rd_val[7:0] = serial_control_reg_r;
      rd_val[NBU_CTRL_SM0_BIT] = framing_detect_select_r ? fe_r : serial_control_reg_r.sm0;
    end else if (i_paddr == NBU_ADDR_MODE) begin
      rd_val[NBU_MODE_FRAMING_DETECT_SELECT_BIT] = framing_detect_select_r;
      rd_val[NBU_MODE_DBL_BIT] = baud_doubler_r;
    end else if (i_paddr == NBU_ADDR_BUF) begin
      rd_val[7:0] = rxbuf_r;
    end else if (i_paddr == NBU_ADDR_PHASE) begin
      rd_val[NBU_PHASE_W-1:0] = phase_r;
    end else if (i_paddr == NBU_ADDR_CLKDIV) begin
      rd_val[NBU_CLKDIV_POWER_MGMT_DIVIDE_ENABLE_BIT:0] = div_r;
    end else begin
      hit = 1'b0;
    end
  end

  assign wr = i_psel & i_penable & i_pwrite & hit;
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
  assign ctrl_wr = wr & (i_paddr == NBU_ADDR_CTRL);
  assign mode_wr = wr & (i_paddr == NBU_ADDR_MODE);
  assign buf_wr = wr & (i_paddr == NBU_ADDR_BUF);
  // writes while a frame is still going out are dropped
  assign buf_wr_ok = buf_wr & (tx_st_r == TX_IDLE);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit;
  assign o_prdata = prdata_r;

  // register file next values; hardware sets win over software clears
  always_comb begin
    serial_control_reg_nxt = serial_control_reg_r;
    fe_nxt = fe_r;
    framing_detect_select_nxt = framing_detect_select_r;
    baud_doubler_nxt = baud_doubler_r;
    phase_nxt = phase_r;
    div_nxt = div_r;
    txbuf_nxt = txbuf_r;
    rxbuf_nxt = rxbuf_r;
    prdata_nxt = rd_setup ? rd_val : prdata_r;
    if (ctrl_wr) begin
      serial_control_reg_nxt = i_pwdata[7:0];
      serial_control_reg_nxt.sm0 = serial_control_reg_r.sm0;
      if (framing_detect_select_r) begin
        fe_nxt = i_pwdata[NBU_CTRL_SM0_BIT];
      end else begin
        serial_control_reg_nxt.sm0 = i_pwdata[NBU_CTRL_SM0_BIT];
      end
    end else if (mode_wr) begin
      framing_detect_select_nxt = i_pwdata[NBU_MODE_FRAMING_DETECT_SELECT_BIT];
      baud_doubler_nxt = i_pwdata[NBU_MODE_DBL_BIT];
    end else if (wr & (i_paddr == NBU_ADDR_PHASE)) begin
      phase_nxt = i_pwdata[NBU_PHASE_W-1:0];
    end else if (wr & (i_paddr == NBU_ADDR_CLKDIV)) begin
      div_nxt = i_pwdata[NBU_CLKDIV_POWER_MGMT_DIVIDE_ENABLE_BIT:0];
    end else if (buf_wr_ok) begin
      txbuf_nxt = i_pwdata[7:0];
    end
    if (tx_ti_set) begin
      serial_control_reg_nxt.ti = 1'b1;
    end
    if (rx_load) begin
      rxbuf_nxt = rx_shift_r;
      serial_control_reg_nxt.rb8 = rx_bit;
      serial_control_reg_nxt.ri = 1'b1;
    end
    if (rx_fe_set) begin
      fe_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      serial_control_reg_r <= NBU_SERIAL_CONTROL_REG_RST;
      fe_r <= 1'b0;
      framing_detect_select_r <= 1'b0;
      baud_doubler_r <= 1'b0;
      phase_r <= '0;
      div_r <= NBU_CLKDIV_RST;
      txbuf_r <= '0;
      rxbuf_r <= '0;
      prdata_r <= '0;
    end else begin
      serial_control_reg_r <= serial_control_reg_nxt;
      fe_r <= fe_nxt;
      framing_detect_select_r <= framing_detect_select_nxt;
      baud_doubler_r <= baud_doubler_nxt;
      phase_r <= phase_nxt;
      div_r <= div_nxt;
      txbuf_r <= txbuf_nxt;
      rxbuf_r <= rxbuf_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // baud timing: system divide feeds modes 0 and 2 only
  always_comb begin
    sys_last = div_r.power_mgmt_divide_enable ? NBU_POWER_MGMT_DIVIDE_ENABLE_LAST : NBU_DIV_LAST[div_r.sel];
    eff_tick = (sys_cnt_r == sys_last);
    sys_cnt_nxt = eff_tick ? '0 : sys_cnt_r + 8'h01;
    m2_tick = eff_tick & (m2_cnt_r == (baud_doubler_r ? NBU_M2_LAST2 : NBU_M2_LAST4));
    m2_cnt_nxt = m2_cnt_r;
    if (eff_tick) begin
      m2_cnt_nxt = m2_tick ? '0 : m2_cnt_r + 2'h1;
    end
    m0_last = serial_control_reg_r.sm2 ? NBU_M0_LAST4 : NBU_M0_LAST12;
    m0_half = serial_control_reg_r.sm2 ? NBU_M0_HALF4 : NBU_M0_HALF12;
    m0_tick = eff_tick & (m0_cnt_r >= m0_last);
    m0_cnt_nxt = m0_cnt_r;
    if (eff_tick) begin
      m0_cnt_nxt = m0_tick ? '0 : m0_cnt_r + 4'h1;
    end
    // restart the shift clock on a write so the first bit gets a full low half
    if (buf_wr_ok & (mode == NBU_MODE_SYNC)) begin
      m0_cnt_nxt = '0;
    end
    gen_cnt_nxt = gen_cnt_r + 2'h1;
    gen_step = baud_doubler_r | (gen_cnt_r == NBU_GEN_SLOW_LAST);
    sub_tick = (mode == NBU_MODE_SYSCLK9) ? m2_tick : gen_pulse;
    roll = sub_tick & (sub16_r == NBU_SUB_LAST);
    sub16_nxt = sub_tick ? sub16_r + 4'h1 : sub16_r;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sys_cnt_r <= '0;
      m2_cnt_r <= '0;
      m0_cnt_r <= '0;
      gen_cnt_r <= '0;
      sub16_r <= '0;
    end else begin
      sys_cnt_r <= sys_cnt_nxt;
      m2_cnt_r <= m2_cnt_nxt;
      m0_cnt_r <= m0_cnt_nxt;
      gen_cnt_r <= gen_cnt_nxt;
      sub16_r <= sub16_nxt;
    end
  end

  nbu_phase_acc u_gen (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_step(gen_step),
    .i_phase(phase_r),
    .o_pulse(gen_pulse)
  );

  // transmitter; mode 0 shifts data on the receive pin with its own clock
  always_comb begin
    tx_st_nxt = tx_st_r;
    frame_nxt = frame_r;
    tx_idx_nxt = tx_idx_r;
    tx_sub_nxt = tx_sub_r;
    dly_nxt = dly_r;
    txd_nxt = txd_r;
    tx_ti_set = 1'b0;
    tx_last = (mode == NBU_MODE_SYNC) ? NBU_LAST_SYNC :
              (mode == NBU_MODE_ASYNC8) ? NBU_LAST_ASYNC8 : NBU_LAST_9BIT;
    tx_bit_end = (mode == NBU_MODE_SYNC) ? m0_tick : (sub_tick & (tx_sub_r == NBU_SUB_LAST));
    case (tx_st_r)
      TX_IDLE: begin
        txd_nxt = 1'b1;
        if (buf_wr_ok) begin
          tx_idx_nxt = NBU_IDX_START;
          if (mode == NBU_MODE_SYNC) begin
            frame_nxt = {3'h7, i_pwdata[7:0]};
            tx_st_nxt = TX_SHIFT;
          end else if (mode == NBU_MODE_ASYNC8) begin
            frame_nxt = {2'h3, i_pwdata[7:0], 1'b0};
            tx_st_nxt = TX_WAIT;
          end else begin
            frame_nxt = {1'b1, serial_control_reg_r.tb8, i_pwdata[7:0], 1'b0};
            tx_st_nxt = TX_WAIT;
          end
        end
      end
      TX_WAIT: begin
        if (roll) begin
          dly_nxt = NBU_TX_DELAY_CYC - 3'h1;
          tx_st_nxt = TX_DELAY;
        end
      end
      TX_DELAY: begin
        dly_nxt = dly_r - 3'h1;
        if (dly_r == '0) begin
          txd_nxt = frame_r[0];
          tx_sub_nxt = '0;
          tx_st_nxt = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (mode == NBU_MODE_SYNC) begin
          txd_nxt = (m0_cnt_r >= m0_half);
        end
        if (sub_tick) begin
          tx_sub_nxt = tx_sub_r + 4'h1;
        end
        if (tx_bit_end) begin
          if (tx_idx_r == tx_last) begin
            tx_st_nxt = TX_IDLE;
            txd_nxt = 1'b1;
            tx_ti_set = (mode == NBU_MODE_SYNC);
          end else begin
            frame_nxt = {1'b1, frame_r[10:1]};
            tx_idx_nxt = tx_idx_r + 4'h1;
            if (mode != NBU_MODE_SYNC) begin
              txd_nxt = frame_r[1];
              tx_ti_set = (tx_idx_nxt == tx_last);
            end
          end
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_st_r <= TX_IDLE;
      frame_r <= '1;
      tx_idx_r <= '0;
      tx_sub_r <= '0;
      dly_r <= '0;
      txd_r <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      frame_r <= frame_nxt;
      tx_idx_r <= tx_idx_nxt;
      tx_sub_r <= tx_sub_nxt;
      dly_r <= dly_nxt;
      txd_r <= txd_nxt;
    end
  end

  assign o_txd = txd_r;
  assign o_rxd_oe = (tx_st_r == TX_SHIFT) & (mode == NBU_MODE_SYNC);
  assign o_rxd_out = frame_r[0];

  // receive pin passes two flip-flops; the third only delays for edges
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
      rxd_d_r <= 1'b1;
    end else begin
      rxd_s1_r <= i_rxd;
      rxd_s2_r <= rxd_s1_r;
      rxd_d_r <= rxd_s2_r;
    end
  end

  // receiver; the generator counts as running once its phase is nonzero
  always_comb begin
    rx_enable = serial_control_reg_r.ren & (mode != NBU_MODE_SYNC) &
                ((mode == NBU_MODE_SYSCLK9) | (phase_r != '0));
    rx_last = (mode == NBU_MODE_ASYNC8) ? NBU_LAST_ASYNC8 : NBU_LAST_9BIT;
    rx_st_nxt = rx_st_r;
    rx_sub_nxt = rx_sub_r;
    rx_idx_nxt = rx_idx_r;
    votes_nxt = votes_r;
    rx_shift_nxt = rx_shift_r;
    rx_mid = (rx_st_r == RX_BITS) & sub_tick & (rx_sub_r == NBU_SAMPLE_C);
    rx_bit = (votes_r[0] & votes_r[1]) | (votes_r[0] & rxd_s2_r) |
             (votes_r[1] & rxd_s2_r);
    rx_abort = rx_mid & (rx_idx_r == NBU_IDX_START) & rx_bit;
    rx_accept = ~serial_control_reg_r.ri & (~serial_control_reg_r.sm2 | rx_bit);
    rx_load = rx_mid & rx_accept &
              (((mode == NBU_MODE_ASYNC8) & (rx_idx_r == rx_last)) |
               ((mode != NBU_MODE_ASYNC8) & (rx_idx_r == NBU_IDX_NINTH)));
    rx_fe_set = rx_mid & (rx_idx_r == rx_last) & ~rx_bit;
    case (rx_st_r)
      RX_IDLE: begin
        if (rx_enable & rxd_d_r & ~rxd_s2_r) begin
          rx_st_nxt = RX_BITS;
          rx_sub_nxt = '0;
          rx_idx_nxt = NBU_IDX_START;
        end
      end
      RX_BITS: begin
        if (sub_tick) begin
          rx_sub_nxt = rx_sub_r + 4'h1;
          if (rx_sub_r == NBU_SAMPLE_A) begin
            votes_nxt[0] = rxd_s2_r;
          end
          if (rx_sub_r == NBU_SAMPLE_B) begin
            votes_nxt[1] = rxd_s2_r;
          end
          if (rx_sub_r == NBU_SUB_LAST) begin
            rx_idx_nxt = rx_idx_r + 4'h1;
          end
        end
        if (rx_mid & (rx_idx_r != NBU_IDX_START) & (rx_idx_r <= NBU_LAST_SYNC + 4'h1)) begin
          rx_shift_nxt = {rx_bit, rx_shift_r[7:1]};
        end
        if (~rx_enable | rx_abort | (rx_mid & (rx_idx_r == rx_last))) begin
          rx_st_nxt = RX_IDLE;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st_r <= RX_IDLE;
      rx_sub_r <= '0;
      rx_idx_r <= '0;
      votes_r <= '0;
      rx_shift_r <= '0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_sub_r <= rx_sub_nxt;
      rx_idx_r <= rx_idx_nxt;
      votes_r <= votes_nxt;
      rx_shift_r <= rx_shift_nxt;
    end
  end

  // checks on the design's own behaviour
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence tx_hold_s;
    (tx_st_r == TX_DELAY) [*5];
  endsequence
  tx_start_delay_a: assert property (
    (tx_st_r == TX_WAIT) && roll |=> tx_hold_s ##1 (o_txd == 1'b0))
    else $error("start bit not driven five cycles after rollover");
  tx_ninth_bit_a: assert property (
    buf_wr_ok && (mode[1] == 1'b1) |=> frame_r[NBU_IDX_NINTH] == $past(serial_control_reg_r.tb8))
    else $error("ninth transmit bit not taken from control");
  tx_done_stop_a: assert property (
    tx_ti_set && (mode != NBU_MODE_SYNC) |=> o_txd && serial_control_reg_r.ti)
    else $error("done flag not set with stop bit");
  rx_accept_load_a: assert property (
    rx_load |=> serial_control_reg_r.ri && (rxbuf_r == $past(rx_shift_r)))
    else $error("accepted word not loaded");
  rx_reject_keep_a: assert property (
    rx_mid && (rx_idx_r == NBU_IDX_NINTH) && (mode[1] == 1'b1) && !rx_accept
    && !wr |=> $stable(rxbuf_r) && $stable(serial_control_reg_r.rb8) && $stable(serial_control_reg_r.ri))
    else $error("rejected word altered state");
  fe_sticky_a: assert property (
    fe_r && !(ctrl_wr && framing_detect_select_r) |=> fe_r)
    else $error("framing error cleared by hardware");
  sel_keeps_mode_a: assert property (
    mode_wr |=> $stable(serial_control_reg_r.sm0) && (fe_r || !$past(fe_r)))
    else $error("select change altered stored bits");
  gen_slow_step_a: assert property (
    gen_step && !baud_doubler_r |=> (!gen_step || baud_doubler_r) [*3])
    else $error("generator stepped too often without doubler");
  start_abort_a: assert property (
    rx_abort && !ctrl_wr |=> (rx_st_r == RX_IDLE) && !$rose(serial_control_reg_r.ri))
    else $error("high start bit not abandoned");
endmodule // nbu_uart

// ---- nbu_pkg.sv ----
// shared constants, register map and types of the nine-bit serial port
package nbu_pkg;
  // register word addresses on the apb bus
  localparam logic [11:0] NBU_ADDR_CTRL = 12'h000;
  localparam logic [11:0] NBU_ADDR_MODE = 12'h004;
  localparam logic [11:0] NBU_ADDR_BUF = 12'h008;
  localparam logic [11:0] NBU_ADDR_PHASE = 12'h00C;
  localparam logic [11:0] NBU_ADDR_CLKDIV = 12'h010;
  // field positions
  localparam int NBU_CTRL_SM0_BIT = 7;
  localparam int NBU_MODE_FRAMING_DETECT_SELECT_BIT = 0;
  localparam int NBU_MODE_DBL_BIT = 1;
  localparam int NBU_CLKDIV_POWER_MGMT_DIVIDE_ENABLE_BIT = 2;
  localparam int NBU_PHASE_W = 16;
  // serial modes, coded as {mode_select_bit0, mode_select_bit1}
  localparam logic [1:0] NBU_MODE_SYNC = 2'h0;
  localparam logic [1:0] NBU_MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] NBU_MODE_SYSCLK9 = 2'h2;
  localparam logic [1:0] NBU_MODE_GEN9 = 2'h3;
  // frame bit indices
  localparam logic [3:0] NBU_IDX_START = 4'h0;
  localparam logic [3:0] NBU_IDX_NINTH = 4'h9;
  localparam logic [3:0] NBU_LAST_SYNC = 4'h7;
  localparam logic [3:0] NBU_LAST_ASYNC8 = 4'h9;
  localparam logic [3:0] NBU_LAST_9BIT = 4'hA;
  // divide-by-16 counter and its vote points (7th, 8th, 9th tick)
  localparam logic [3:0] NBU_SUB_LAST = 4'hF;
  localparam logic [3:0] NBU_SAMPLE_A = 4'h6;
  localparam logic [3:0] NBU_SAMPLE_B = 4'h7;
  localparam logic [3:0] NBU_SAMPLE_C = 4'h8;
  // transmit start delay after the counter rollover
  localparam logic [2:0] NBU_TX_DELAY_CYC = 3'h5;
  // mode 0 shift clock period and low half, in divided system clocks
  localparam logic [3:0] NBU_M0_LAST12 = 4'hB;
  localparam logic [3:0] NBU_M0_LAST4 = 4'h3;
  localparam logic [3:0] NBU_M0_HALF12 = 4'h6;
  localparam logic [3:0] NBU_M0_HALF4 = 4'h2;
  // mode 2 feed divider: by 2 with doubler, by 4 without
  localparam logic [1:0] NBU_M2_LAST2 = 2'h1;
  localparam logic [1:0] NBU_M2_LAST4 = 2'h3;
  // phase generator steps every 4th clock without doubler
  localparam logic [1:0] NBU_GEN_SLOW_LAST = 2'h3;
  // system clock divide: by 1, 2, 4, 8, or 256 in power management
  localparam logic [7:0] NBU_DIV_LAST [0:3] = '{8'h00, 8'h01, 8'h03, 8'h07};
  localparam logic [7:0] NBU_POWER_MGMT_DIVIDE_ENABLE_LAST = 8'hFF;
  localparam logic [31:0] NBU_RDATA_NONE = 32'h0000_0000;

  // serial control register, msb first
  typedef struct packed {
    logic sm0;
    logic sm1;
    logic sm2;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
  } nbu_serial_control_reg_t;
  localparam nbu_serial_control_reg_t NBU_SERIAL_CONTROL_REG_RST = '0;

  // system clock divide selection
  typedef struct packed {
    logic power_mgmt_divide_enable;
    logic [1:0] sel;
  } nbu_clkdiv_t;
  localparam nbu_clkdiv_t NBU_CLKDIV_RST = '0;

  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_DELAY, TX_SHIFT} nbu_tx_state_t;
  typedef enum logic {RX_IDLE, RX_BITS} nbu_rx_state_t;
endpackage : nbu_pkg

// ---- nbu_phase_acc.sv ----
// phase accumulator baud generator
module nbu_phase_acc
  import nbu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_step,
  input wire logic [NBU_PHASE_W-1:0] i_phase,
  output logic o_pulse
);
  logic [NBU_PHASE_W-1:0] acc_r;
  logic [NBU_PHASE_W-1:0] acc_nxt;
  logic pulse_r;
  logic pulse_nxt;
  logic [NBU_PHASE_W:0] sum;

  // add the phase on each step; the carry out is one generator pulse
  always_comb begin
    sum = {1'b0, acc_r} + {1'b0, i_phase};
    acc_nxt = i_step ? sum[NBU_PHASE_W-1:0] : acc_r;
    pulse_nxt = i_step & sum[NBU_PHASE_W];
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_r <= '0;
      pulse_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign o_pulse = pulse_r;
endmodule // nbu_phase_acc

// ---- nbu_node.sv ----
// remote serial node model: sends frames to the port and captures the frames it sends
module nbu_node (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_bit_clks,
  input wire logic i_line,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] cap_bits;
  int n_frames;
  int k;
  // released line sits at the mark level, as its pull-up would hold it
  initial begin
    o_line = 1'b1;
    n_frames = 0;
  end
  // capture start, data lsb first, ninth, stop at mid bit
  initial forever begin
    @(negedge i_line);
    repeat (i_bit_clks / 2) @(posedge i_clk_sys);
    for (k = 0; k < 11; k++) begin
      cap_bits[k] = i_line;
      if (k < 10) repeat (i_bit_clks) @(posedge i_clk_sys);
    end
    n_frames++;
  end
  // one 11-bit frame; a low stop is only sent when a scenario asks for it
  task automatic send(input logic [7:0] d, input logic n, input logic s);
    logic [10:0] f;
    f = {s, n, d, 1'b0};
    for (int b = 0; b < 11; b++) begin
      @(posedge i_clk_sys);
      o_line <= f[b];
      repeat (i_bit_clks - 1) @(posedge i_clk_sys);
    end
    @(posedge i_clk_sys);
    o_line <= 1'b1;
  endtask
  // low pulse too short to survive the start-bit vote
  task automatic glitch();
    @(posedge i_clk_sys);
    o_line <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    o_line <= 1'b1;
  endtask
endmodule // nbu_node

// ---- test_nine_bit_uart_baud_framing.sv ----
// self-checking bench of the nine-bit serial port
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module test_nine_bit_uart_baud_framing;
  timeunit 1ns;
  timeprecision 1ns;
  import nbu_pkg::*;
  typedef struct packed {logic [7:0] md; logic [7:0] ctl; logic [7:0] d;} nbu_tx_row_t;
  typedef struct packed {logic [7:0] ctl; logic [7:0] d; logic n; logic clr; logic acc;} nbu_rx_row_t;
  // tx rows: mode reg, control, data; doubler off in the middle row doubles the bit time
  localparam nbu_tx_row_t TX_ROWS [3] = '{{8'h02, 8'h88, 8'h96}, {8'h00, 8'h80, 8'h01},
    {8'h02, 8'hC8, 8'h80}};
  // rx rows: control, data, ninth, clear done first, accepted
  localparam nbu_rx_row_t RX_ROWS [6] = '{{8'h90, 8'hA5, 3'h3}, {8'hB0, 8'h3C, 3'h2},
    {8'hB0, 8'h5A, 3'h7}, {8'hB0, 8'h11, 3'h4}, {8'hD0, 8'hE7, 3'h7}, {8'h80, 8'h42, 3'h6}};
  logic clk, rst_n, psel, penable, pwrite, rxd, pready, pslverr, rxd_out, rxd_oe, txd, sl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] bitc, exp_buf;
  logic exp_rb8, exp_ri;
  int num_errors = 0;
  int num_checks = 0;
  int f0;
  logic [7:0] m0_cap;
  time t0;

  nbu_uart dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd), .o_rxd_out(rxd_out),
    .o_rxd_oe(rxd_oe), .o_txd(txd));
  nbu_node node_u (.i_clk_sys(clk), .i_bit_clks(bitc), .i_line(txd), .o_line(rxd));

  // 100 ns system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // apb transfer; the request is held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded wait for the node to finish capturing a frame
  task automatic wait_frame();
    for (int i = 0; i < 4000 && node_u.n_frames == f0; i++) @(posedge clk);
    if (node_u.n_frames == f0) num_errors++;
    // capture ends at mid stop; let the stop bit finish before the next buffer write
    repeat (bitc) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  // main sequence: reset, tx table, rx table, then hand-written cases
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    rst_n = 1'b0; bitc = 8'h20; exp_buf = 8'h00; exp_rb8 = 1'b0; exp_ri = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, NBU_ADDR_CTRL, '0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, NBU_ADDR_MODE, '0);
    `CHK(rd, 32'h0000_0000)
    `CHK(txd, 1'b1)
    apb(1'b1, NBU_ADDR_PHASE, 32'h0000_8000);
    apb(1'b0, NBU_ADDR_PHASE, '0);
    `CHK(rd, 32'h0000_8000)
    // transmit: 8000 phase with doubler gives a carry every 2 clocks, so 32-clock bits
    foreach (TX_ROWS[r]) begin
      bitc <= TX_ROWS[r].md[1] ? 8'h20 : 8'h40;
      apb(1'b1, NBU_ADDR_MODE, {24'h0, TX_ROWS[r].md});
      apb(1'b1, NBU_ADDR_CTRL, {24'h0, TX_ROWS[r].ctl});
      f0 = node_u.n_frames;
      apb(1'b1, NBU_ADDR_BUF, {24'h0, TX_ROWS[r].d});
      wait_frame();
      `CHK(node_u.cap_bits, {1'b1, TX_ROWS[r].ctl[3], TX_ROWS[r].d, 1'b0})
      apb(1'b0, NBU_ADDR_CTRL, '0);
      `CHK(rd[1], 1'b1)
    end
    // receive: acceptance by done flag, multiprocessor bit and enable
    foreach (RX_ROWS[r]) begin
      if (RX_ROWS[r].clr) begin
        apb(1'b1, NBU_ADDR_CTRL, {24'h0, RX_ROWS[r].ctl});
        exp_ri = 1'b0;
        exp_rb8 = RX_ROWS[r].ctl[2];
      end
      node_u.send(RX_ROWS[r].d, RX_ROWS[r].n, 1'b1);
      if (RX_ROWS[r].acc) begin
        exp_buf = RX_ROWS[r].d;
        exp_rb8 = RX_ROWS[r].n;
        exp_ri = 1'b1;
      end
      apb(1'b0, NBU_ADDR_CTRL, '0);
      `CHK({rd[2], rd[0]}, {exp_rb8, exp_ri})
      apb(1'b0, NBU_ADDR_BUF, '0);
      `CHK(rd[7:0], exp_buf)
    end
    // false start, then a frame with a low stop bit while the flag view is selected
    apb(1'b1, NBU_ADDR_CTRL, 32'h0000_0090);
    apb(1'b1, NBU_ADDR_MODE, 32'h0000_0003);
    node_u.glitch();
    repeat (64) @(posedge clk);
    node_u.send(8'hC3, 1'b1, 1'b0);
    apb(1'b0, NBU_ADDR_CTRL, '0);
    `CHK({rd[7], rd[0]}, 2'h3)
    apb(1'b0, NBU_ADDR_BUF, '0);
    `CHK(rd[7:0], 8'hC3)
    // clear done with the mode view, so the write cannot touch the error flag
    apb(1'b1, NBU_ADDR_MODE, 32'h0000_0002);
    apb(1'b1, NBU_ADDR_CTRL, 32'h0000_0090);
    apb(1'b1, NBU_ADDR_MODE, 32'h0000_0003);
    node_u.send(8'h24, 1'b0, 1'b1);
    apb(1'b0, NBU_ADDR_CTRL, '0);
    `CHK({rd[7], rd[0]}, 2'h3)
    apb(1'b1, NBU_ADDR_CTRL, 32'h0000_0010);
    apb(1'b0, NBU_ADDR_CTRL, '0);
    `CHK(rd[7], 1'b0)
    apb(1'b1, NBU_ADDR_MODE, 32'h0000_0002);
    apb(1'b0, NBU_ADDR_CTRL, '0);
    `CHK(rd[7:4], 4'h9)
    // unmapped address is refused and reads zero
    apb(1'b0, 12'h014, '0);
    `CHK({sl, rd}, {1'b1, 32'h0000_0000})
    // system clock over 2 doubles the mode 2 bit time
    apb(1'b1, NBU_ADDR_CLKDIV, 32'h0000_0001);
    bitc <= 8'h40;
    f0 = node_u.n_frames;
    apb(1'b1, NBU_ADDR_BUF, 32'h0000_005C);
    wait_frame();
    `CHK(node_u.cap_bits, {2'h2, 8'h5C, 1'b0})
    apb(1'b1, NBU_ADDR_CLKDIV, 32'h0000_0000);
    // mode 0 at clock over 4: eight bits lsb first, latched on each rising shift clock
    apb(1'b1, NBU_ADDR_CTRL, 32'h0000_0020);
    apb(1'b1, NBU_ADDR_BUF, 32'h0000_00B4);
    for (int b = 0; b < 8; b++) begin
      @(posedge txd);
      if (b == 0) t0 = $time;
      m0_cap = {rxd_out, m0_cap[7:1]};
      `CHK(rxd_oe, 1'b1)
    end
    `CHK($time - t0, 64'h0000_0000_0000_0AF0)
    `CHK(m0_cap, 8'hB4)
    repeat (4) @(posedge clk);
    `CHK(rxd_oe, 1'b0)
    // a second reset must clear the doubler again
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, NBU_ADDR_MODE, '0);
    `CHK(rd[1], 1'b0)
    tally_and_finish();
  end
endmodule // test_nine_bit_uart_baud_framing
